// >>> pkg/adcc_defines.svh
// Register offsets, field positions, reset values and timing counts of the conversion control
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH
`define ADCC_OFF_CONV_CTRL   12'h000
`define ADCC_OFF_PIN_FUNC    12'h004
`define ADCC_OFF_CLK_CTRL    12'h008
`define ADCC_OFF_RES_LOW     12'h00c
`define ADCC_OFF_RES_HIGH    12'h010
`define ADCC_OFF_IRQ_CTRL    12'h014
`define ADCC_BIT_START       7
`define ADCC_BIT_BUSY        6
`define ADCC_BIT_OFF         6
`define ADCC_BIT_TEST        7
`define ADCC_BIT_IRQ_FLAG    6
`define ADCC_BIT_IRQ_EN      3
`define ADCC_BIT_GLOBAL_EN   0
`define ADCC_CLK_CTRL_RST    8'h80
`define ADCC_CONV_PERIODS    5'h10
`define ADCC_SAMPLE_PERIODS  5'h04
`define ADCC_SEL_DIV2        3'h0
`define ADCC_SEL_DIV8        3'h1
`define ADCC_SEL_DIV32       3'h2
`define ADCC_SEL_DIV1        3'h4
`define ADCC_SEL_DIV4        3'h5
`define ADCC_SEL_DIV16       3'h6
`endif

// >>> pkg/adcc_pkg.sv
// Types shared by the conversion control files
package adcc_pkg;
   typedef enum logic [1:0] {
      ADCC_IDLE,
      ADCC_HOLD,
      ADCC_CONV
   } adcc_state_e;
   typedef logic [7:0] adcc_byte_t;
endpackage

// >>> verilog/adcc_clk_div.sv
// Conversion clock divider producing a one-cycle enable per conversion clock period
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_clk_div #(
   parameter int DIV_W = 5
) (
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       restart,
   input  wire logic [2:0] clkSel,
   output var  logic       convTick
);
   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] cnt_nxt;
   logic [DIV_W-1:0] limit;
   logic             tick_nxt;

   // Terminal count from select code; undefined codes fall back to the slowest rate
   always_comb begin
      case (clkSel) //RULE7
         `ADCC_SEL_DIV1:  limit = DIV_W'(0);
         `ADCC_SEL_DIV2:  limit = DIV_W'(1);
         `ADCC_SEL_DIV4:  limit = DIV_W'(3);
         `ADCC_SEL_DIV8:  limit = DIV_W'(7);
         `ADCC_SEL_DIV16: limit = DIV_W'(15);
         `ADCC_SEL_DIV32: limit = DIV_W'(31);
         default:         limit = DIV_W'(31);
      endcase
   end

   // Restart aligns the first period with the start of the conversion
   always_comb begin
      if (restart || cnt_r >= limit) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + DIV_W'(1);
      end
      tick_nxt = !restart && (cnt_r >= limit); //RULE7
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r    <= '0;
         convTick <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         convTick <= tick_nxt;
      end
   end

   // No tick arrives in the cycle right after a restart cycle
   AST_DIV_SPACING: assert property (@(posedge mclk) disable iff (sys_rst) //RULE7
      restart |=> !convTick) else $error("Tick right after restart");
endmodule
`default_nettype wire

// >>> verilog/adcc_conv_ctrl.sv
// APB conversion control: start sequence, busy flag, clock divide, power and pin function
//
// Functional notes
// RULE1: Start bit rise then fall starts conversion
// RULE2: Start held high resets converter, busy set
// RULE3: Busy clears when conversion finishes
// RULE4: Completion sets flag; request needs enables
// RULE5: Accepted request vectors CPU to handler
// RULE6: Firmware may poll busy flag instead
// RULE7: Select code sets conversion clock divide
// RULE8: Firmware picks only defined divide codes
// RULE9: Power on: pins selected, off bit clear
// RULE10: Halt does not alter converter power
// RULE11: Firmware keeps clock period 0.5 to 10us
// RULE12: Above 4MHz, firmware avoids code 000
// RULE13: Each select bit switches its pin
// RULE14: Analog pin drops its pull-up
// RULE15: Analog pin ignores port direction
// RULE16: Firmware follows documented setup order
// RULE17: Interrupt use needs both enables set
// RULE18: Firmware reads result bytes after busy
// RULE19: Conversion lasts sixteen conversion clocks
// RULE20: Result left aligned across two bytes
// RULE21: Channel field routes input to converter
// RULE22: Select bit one means analog input
// RULE23: Start falling edge launches divided sequencer
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_conv_ctrl #(
   parameter int NPINS = 8,
   parameter int RES_W = 12
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output var  logic [31:0]      prdata,
   output var  logic             pready,
   output var  logic             pslverr,
   input  wire logic [RES_W-1:0] convData,
   input  wire logic [NPINS-1:0] pullUpCfg,
   input  wire logic [NPINS-1:0] portDirIn,
   output var  logic             convPowerOn,
   output var  logic             convReset,
   output var  logic             convSample,
   output var  logic             convClkEn,
   output var  logic [2:0]       channelSel,
   output var  logic [NPINS-1:0] analogPinEn,
   output var  logic [NPINS-1:0] pullUpEn,
   output var  logic [NPINS-1:0] portDirOut,
   output var  logic             irqReq
);
   // Software-visible control state
   adcc_pkg::adcc_byte_t convCtrl_r, convCtrl_nxt;
   adcc_pkg::adcc_byte_t pinFunc_r, pinFunc_nxt;
   adcc_pkg::adcc_byte_t clkCtrl_r, clkCtrl_nxt;
   adcc_pkg::adcc_byte_t irqCtrl_r, irqCtrl_nxt;
   logic [RES_W-1:0]     result_r, result_nxt;
   logic [31:0]          prdata_nxt;
   logic                 pslverr_nxt;
   // Sequencer state
   adcc_pkg::adcc_state_e state_r, state_nxt;
   logic [4:0]           period_r, period_nxt;
   logic                 busy_r, busy_nxt;
   logic                 startPrev_r;
   logic                 done;
   logic                 convTick;
   logic                 wrAccess;
   logic                 rdSetup;
   logic                 powerOn;
   logic [NPINS-1:0]     pinSel;

   // Zero-wait slave: every access completes in its first access cycle
   // Reads decode in the setup cycle so data and error stand beside pready
   assign wrAccess = psel && penable && pwrite;
   assign rdSetup  = psel && !penable && !pwrite;
   assign pinSel   = pinFunc_r[NPINS-1:0];

   // Power depends only on pin selection and the off bit; no halt input exists
   assign powerOn = (|pinSel) && !clkCtrl_r[`ADCC_BIT_OFF]; //RULE9 RULE10

   // Conversion clock enable, restarted at the start edge
   adcc_clk_div #(
      .DIV_W (5)
   ) uDiv (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .restart  (state_r != adcc_pkg::ADCC_CONV),
      .clkSel   (clkCtrl_r[2:0]),
      .convTick (convTick)
   );

   // Sequencer: rise holds reset, fall launches sixteen conversion periods
   always_comb begin
      state_nxt  = state_r;
      period_nxt = period_r;
      busy_nxt   = busy_r;
      done       = 1'b0;
      case (state_r)
         adcc_pkg::ADCC_IDLE: begin
            if (convCtrl_r[`ADCC_BIT_START] && !startPrev_r) begin
               state_nxt = adcc_pkg::ADCC_HOLD; //RULE2
               busy_nxt  = 1'b1; //RULE2
            end
         end
         adcc_pkg::ADCC_HOLD: begin
            busy_nxt = 1'b1; //RULE2
            if (!convCtrl_r[`ADCC_BIT_START]) begin
               state_nxt  = adcc_pkg::ADCC_CONV; //RULE1 RULE23
               period_nxt = '0;
            end
         end
         adcc_pkg::ADCC_CONV: begin
            if (convCtrl_r[`ADCC_BIT_START]) begin
               state_nxt = adcc_pkg::ADCC_HOLD; // New rise aborts and resets
            end else if (convTick && powerOn) begin
               if (period_r == `ADCC_CONV_PERIODS - 5'h01) begin //RULE19
                  state_nxt = adcc_pkg::ADCC_IDLE;
                  busy_nxt  = 1'b0; //RULE3
                  done      = 1'b1;
               end else begin
                  period_nxt = period_r + 5'h01;
               end
            end
         end
         default: begin
            state_nxt = adcc_pkg::ADCC_IDLE;
         end
      endcase
   end

   // Register writes; completion sets the request flag and wins over a clear
   always_comb begin
      convCtrl_nxt = convCtrl_r;
      pinFunc_nxt  = pinFunc_r;
      clkCtrl_nxt  = clkCtrl_r;
      irqCtrl_nxt  = irqCtrl_r;
      result_nxt   = result_r;
      if (wrAccess) begin
         case (paddr)
            `ADCC_OFF_CONV_CTRL: begin
               convCtrl_nxt = {pwdata[7], 4'h0, pwdata[2:0]};
            end
            `ADCC_OFF_PIN_FUNC:  pinFunc_nxt = pwdata[7:0]; //RULE13
            `ADCC_OFF_CLK_CTRL:  clkCtrl_nxt = {pwdata[7:6], 3'h0, pwdata[2:0]};
            `ADCC_OFF_IRQ_CTRL:  irqCtrl_nxt = {1'b0, pwdata[6], 2'h0, pwdata[3], 2'h0, pwdata[0]};
            default: begin
            end
         endcase
      end
      if (done) begin
         irqCtrl_nxt[`ADCC_BIT_IRQ_FLAG] = 1'b1; //RULE4
         result_nxt = convData;
      end
   end

   // Read mux: busy lives in the control byte, result left aligned
   // Registered at the setup edge, so the answer is whatever stood in setup
   always_comb begin
      prdata_nxt  = 32'h0;
      pslverr_nxt = 1'b0;
      if (rdSetup) begin
         case (paddr)
            `ADCC_OFF_CONV_CTRL: prdata_nxt = {24'h0, convCtrl_r[7], busy_r, convCtrl_r[5:0]};
            `ADCC_OFF_PIN_FUNC:  prdata_nxt = {24'h0, pinFunc_r};
            `ADCC_OFF_CLK_CTRL:  prdata_nxt = {24'h0, clkCtrl_r};
            `ADCC_OFF_RES_LOW:   prdata_nxt = {24'h0, result_r[3:0], 4'h0}; //RULE20
            `ADCC_OFF_RES_HIGH:  prdata_nxt = {24'h0, result_r[11:4]}; //RULE20
            `ADCC_OFF_IRQ_CTRL:  prdata_nxt = {24'h0, irqCtrl_r};
            default:             pslverr_nxt = 1'b1;
         endcase
      end else if (psel && !penable) begin
         case (paddr)
            `ADCC_OFF_CONV_CTRL, `ADCC_OFF_PIN_FUNC, `ADCC_OFF_CLK_CTRL,
            `ADCC_OFF_RES_LOW, `ADCC_OFF_RES_HIGH, `ADCC_OFF_IRQ_CTRL: pslverr_nxt = 1'b0;
            default: pslverr_nxt = 1'b1;
         endcase
      end
   end

   // Registers; busy resets high as the control byte does at power-on
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         convCtrl_r  <= 8'h00;
         pinFunc_r   <= 8'h00;
         clkCtrl_r   <= `ADCC_CLK_CTRL_RST;
         irqCtrl_r   <= 8'h00;
         result_r    <= '0;
         state_r     <= adcc_pkg::ADCC_IDLE;
         period_r    <= 5'h00;
         busy_r      <= 1'b1;
         startPrev_r <= 1'b0;
      end else begin
         convCtrl_r  <= convCtrl_nxt;
         pinFunc_r   <= pinFunc_nxt;
         clkCtrl_r   <= clkCtrl_nxt;
         irqCtrl_r   <= irqCtrl_nxt;
         result_r    <= result_nxt;
         state_r     <= state_nxt;
         period_r    <= period_nxt;
         busy_r      <= busy_nxt;
         startPrev_r <= convCtrl_r[`ADCC_BIT_START];
      end
   end

   // Pin overrides per pin: analog use drops pull-up and forces input direction
   logic [NPINS-1:0] pullUp_nxt;
   logic [NPINS-1:0] dir_nxt;
   for (genvar i = 0; i < NPINS; i++) begin : gPin
      assign pullUp_nxt[i] = pinSel[i] ? 1'b0 : pullUpCfg[i]; //RULE14 RULE22
      assign dir_nxt[i]    = pinSel[i] ? 1'b1 : portDirIn[i]; //RULE15
   end

   // All outputs registered; the bus answer too
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata      <= 32'h0;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         convPowerOn <= 1'b0;
         convReset   <= 1'b1;
         convSample  <= 1'b0;
         convClkEn   <= 1'b0;
         channelSel  <= 3'h0;
         analogPinEn <= '0;
         pullUpEn    <= '0;
         portDirOut  <= '1;
         irqReq      <= 1'b0;
      end else begin
         prdata      <= prdata_nxt;
         pready      <= psel && !penable; // Answer one cycle after setup
         pslverr     <= pslverr_nxt;
         convPowerOn <= powerOn; //RULE9
         convReset   <= state_r != adcc_pkg::ADCC_CONV; //RULE2
         convSample  <= state_r == adcc_pkg::ADCC_CONV && period_r < `ADCC_SAMPLE_PERIODS;
         convClkEn   <= convTick && state_r == adcc_pkg::ADCC_CONV;
         channelSel  <= convCtrl_r[2:0]; //RULE21
         analogPinEn <= pinSel; //RULE13 RULE22
         pullUpEn    <= pullUp_nxt;
         portDirOut  <= dir_nxt;
         irqReq      <= irqCtrl_nxt[`ADCC_BIT_IRQ_FLAG] && irqCtrl_nxt[`ADCC_BIT_IRQ_EN]
                        && irqCtrl_nxt[`ADCC_BIT_GLOBAL_EN]; //RULE4 RULE5
      end
   end

   // Checks
   sequence sStartRise;
      state_r == adcc_pkg::ADCC_IDLE && convCtrl_r[`ADCC_BIT_START] && !startPrev_r;
   endsequence
   sequence sStartFall;
      state_r == adcc_pkg::ADCC_HOLD && !convCtrl_r[`ADCC_BIT_START];
   endsequence

   AST_RISE_BUSY: assert property (@(posedge mclk) disable iff (sys_rst) //RULE2
      sStartRise |=> busy_r && state_r == adcc_pkg::ADCC_HOLD) else $error("Rise no busy");
   AST_HOLD_BUSY: assert property (@(posedge mclk) disable iff (sys_rst) //RULE2
      state_r == adcc_pkg::ADCC_HOLD |=> busy_r) else $error("Busy low in hold");
   AST_FALL_CONV: assert property (@(posedge mclk) disable iff (sys_rst) //RULE1
      sStartFall |=> state_r == adcc_pkg::ADCC_CONV) else $error("Fall no start");
   AST_DONE_BUSY: assert property (@(posedge mclk) disable iff (sys_rst) //RULE3
      done |=> !busy_r && irqCtrl_r[`ADCC_BIT_IRQ_FLAG]) else $error("Done not seen");
   AST_IRQ_GATE: assert property (@(posedge mclk) disable iff (sys_rst) //RULE4
      irqReq |-> $past(irqCtrl_nxt[`ADCC_BIT_IRQ_EN])) else $error("Request while off");
   AST_POWER: assert property (@(posedge mclk) disable iff (sys_rst) //RULE9
      convPowerOn |-> $past(|pinSel) && !$past(clkCtrl_r[`ADCC_BIT_OFF])) else $error("Bad power");
   AST_PULLUP: assert property (@(posedge mclk) disable iff (sys_rst) //RULE14
      $past(pinSel[0]) |-> !pullUpEn[0] && portDirOut[0]) else $error("Analog pin override");
   AST_PERIODS: assert property (@(posedge mclk) disable iff (sys_rst) //RULE19
      done |-> period_r == 5'h0f) else $error("Wrong period count");
   AST_RESULT: assert property (@(posedge mclk) disable iff (sys_rst) //RULE20
      rdSetup && paddr == `ADCC_OFF_RES_LOW |=> prdata[3:0] == 4'h0) else $error("Low nibble");

   // Bus answer: ready one cycle after setup, one cycle long, error only beside it
   // A late answer would leave the master sampling stale read data
   AST_READY_ONE: assert property (@(posedge mclk) disable iff (sys_rst)
      psel && !penable |=> pready) else $error("No ready after setup");
   AST_READY_PULSE: assert property (@(posedge mclk) disable iff (sys_rst)
      pready |=> !pready) else $error("Ready stands too long");
   AST_ERR_READY: assert property (@(posedge mclk) disable iff (sys_rst)
      pslverr |-> pready) else $error("Error without ready");

   // Converter held in reset whenever no conversion runs, busy shown while one runs
   AST_HOLD_RESET: assert property (@(posedge mclk) disable iff (sys_rst) //RULE2
      state_r != adcc_pkg::ADCC_CONV |=> convReset) else $error("Converter not held");
   AST_BUSY_CONV: assert property (@(posedge mclk) disable iff (sys_rst) //RULE3
      state_r == adcc_pkg::ADCC_CONV |-> busy_r) else $error("Busy low while converting");

   // Channel and pin selects reach their outputs one cycle later
   AST_CHANNEL: assert property (@(posedge mclk) disable iff (sys_rst) //RULE21
      1'b1 |=> channelSel == $past(convCtrl_r[2:0])) else $error("Channel not routed");
   AST_PIN_EN: assert property (@(posedge mclk) disable iff (sys_rst) //RULE13 RULE22
      1'b1 |=> analogPinEn == $past(pinSel)) else $error("Pin select not applied");

   // No request leaves the block while either enable is clear
   AST_IRQ_ENABLES: assert property (@(posedge mclk) disable iff (sys_rst) //RULE4
      !irqCtrl_r[`ADCC_BIT_IRQ_EN] || !irqCtrl_r[`ADCC_BIT_GLOBAL_EN] |-> !irqReq)
      else $error("Request with enables clear");
endmodule
`default_nettype wire

// >>> sim/adcc_conv_model.sv
// Far-side model: analog converter result and port pin logic
`timescale 1ns/1ps
`default_nettype none
module adcc_conv_model (
   input  wire logic        mclk,
   input  wire logic        convPowerOn,
   input  wire logic [2:0]  channelSel,
   output var  logic [11:0] convData,
   output var  logic [7:0]  pullUpCfg,
   output var  logic [7:0]  portDirIn
);
   logic [11:0] level = 12'h000;

   // Result carries the routed channel; unpowered output churns so a stale capture fails
   always @(posedge mclk) begin
      level <= convPowerOn ? {9'h15a, channelSel} : ~level;
   end

   // Port logic asks for every pull-up and inputs on the low nibble
   always_comb begin
      convData  = level;
      pullUpCfg = 8'hff;
      portDirIn = 8'h0f;
   end
endmodule
`default_nettype wire

// >>> sim/adc_conversion_control_tb.sv
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.svh"
module adc_conversion_control_tb;
   logic        mclk, sysRst, psel, penable, pwrite, pready, pslverr, err, seen;
   logic        convPowerOn, convReset, convSample, convClkEn, irqReq;
   logic [11:0] paddr, convData, res;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  pullUpCfg, portDirIn, analogPinEn, pullUpEn, portDirOut;
   logic [2:0]  channelSel;
   logic [2:0]  codes [6] = '{`ADCC_SEL_DIV1, `ADCC_SEL_DIV2, `ADCC_SEL_DIV4,
                              `ADCC_SEL_DIV8, `ADCC_SEL_DIV16, `ADCC_SEL_DIV32};
   int          ratios [6] = '{1, 2, 4, 8, 16, 32};
   int          n_errors = 0, n_checks = 0, nTick = 0, cyc = 0, lastTick = 0, ratio = 1;
   int          nSample = 0;

   adcc_conv_ctrl uut (.mclk(mclk), .sys_rst(sysRst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .convData(convData), .pullUpCfg(pullUpCfg), .portDirIn(portDirIn),
      .convPowerOn(convPowerOn), .convReset(convReset), .convSample(convSample),
      .convClkEn(convClkEn), .channelSel(channelSel), .analogPinEn(analogPinEn),
      .pullUpEn(pullUpEn), .portDirOut(portDirOut), .irqReq(irqReq));
   adcc_conv_model model (.mclk(mclk), .convPowerOn(convPowerOn), .channelSel(channelSel),
      .convData(convData), .pullUpCfg(pullUpCfg), .portDirIn(portDirIn));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   // Setup, then access held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) chk1(1'b0, 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Pin outputs trail their registers by a cycle
   task automatic settle();
      repeat (2) @(negedge mclk);
   endtask

   // Conversion clock enables: spacing within one conversion and total count
   always @(negedge mclk) begin
      cyc <= cyc + 1;
      if (convReset === 1'b1) begin
         seen <= 1'b0;
      end else if (convClkEn === 1'b1) begin
         if (seen === 1'b1) chk(cyc - lastTick, ratio);
         seen     <= 1'b1;
         lastTick <= cyc;
         nTick    <= nTick + 1;
         if (convSample === 1'b1) nSample <= nSample + 1;
      end
   end

   task automatic conv(input logic [2:0] code, input int r, input logic irqOn);
      int n0, s0, k;
      ratio = r;
      apb(1'b1, `ADCC_OFF_CLK_CTRL, {29'h0, code});
      apb(1'b1, `ADCC_OFF_IRQ_CTRL, irqOn ? 32'h09 : 32'h00);
      apb(1'b1, `ADCC_OFF_CONV_CTRL, 32'h83);
      apb(1'b0, `ADCC_OFF_CONV_CTRL, 32'h0);
      chk(rd, 32'hc3);
      chk1(convReset, 1'b1);
      n0 = nTick;
      s0 = nSample;
      apb(1'b1, `ADCC_OFF_CONV_CTRL, 32'h03);
      apb(1'b0, `ADCC_OFF_CONV_CTRL, 32'h0);
      chk(rd, 32'h43);
      k = 0;
      do begin
         apb(1'b0, `ADCC_OFF_CONV_CTRL, 32'h0);
         k++;
      end while (rd[6] !== 1'b0 && k < 300);
      chk(rd, 32'h03);
      chk(nTick - n0, 16);
      chk(nSample - s0, `ADCC_SAMPLE_PERIODS);
      apb(1'b0, `ADCC_OFF_IRQ_CTRL, 32'h0);
      chk(rd, irqOn ? 32'h49 : 32'h40);
      chk1(irqReq, irqOn);
      res = {9'h15a, 3'h3};
      apb(1'b0, `ADCC_OFF_RES_HIGH, 32'h0);
      chk(rd, {24'h0, res[11:4]});
      apb(1'b0, `ADCC_OFF_RES_LOW, 32'h0);
      chk(rd, {24'h0, res[3:0], 4'h0});
      apb(1'b1, `ADCC_OFF_IRQ_CTRL, 32'h0);
      settle();
      chk1(irqReq, 1'b0);
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Main sequence: reset values, unmapped access, pin function, power, conversions
   initial begin
      sysRst  = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      repeat (16) @(posedge mclk);
      sysRst <= 1'b0;
      apb(1'b0, `ADCC_OFF_CONV_CTRL, 32'h0);
      chk(rd, 32'h40);
      apb(1'b0, `ADCC_OFF_CLK_CTRL, 32'h0);
      chk(rd, 32'h80);
      apb(1'b0, 12'h018, 32'h0);
      chk({rd[31:1], err}, 32'h1);
      apb(1'b1, `ADCC_OFF_PIN_FUNC, 32'ha5);
      apb(1'b1, `ADCC_OFF_CLK_CTRL, 32'h01);
      settle();
      chk(analogPinEn, 8'ha5);
      chk(pullUpEn, 8'h5a);
      chk(portDirOut, 8'haf);
      chk1(convPowerOn, 1'b1);
      apb(1'b1, `ADCC_OFF_CLK_CTRL, 32'h41);
      settle();
      chk1(convPowerOn, 1'b0);
      apb(1'b1, `ADCC_OFF_CLK_CTRL, 32'h01);
      apb(1'b1, `ADCC_OFF_PIN_FUNC, 32'h00);
      settle();
      chk1(convPowerOn, 1'b0);
      chk(pullUpEn, 8'hff);
      chk(portDirOut, 8'h0f);
      apb(1'b1, `ADCC_OFF_PIN_FUNC, 32'h08);
      for (int i = 0; i < 6; i++) begin
         conv(codes[i], ratios[i], i == 5);
      end
      // Closing conversion at a clock inside the accurate period range
      conv(`ADCC_SEL_DIV16, 16, 1'b0);
      end_sim();
   end

   // Watchdog well beyond the expected run of under two thousand cycles
   initial begin
      repeat (30000) @(posedge mclk);
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
